// *** common/crc_parity_pkg.sv ***
// Types shared by the checker modules
package crc_parity_pkg;
  typedef enum logic [1:0] {IDLE, BURST, CHECK} burst_state_type;
  typedef enum logic [1:0] {ALERT_IDLE, ALERT_SHORT_PULSE, ALERT_LONG_PULSE} alert_state_type;
endpackage

// *** common/crc_parity_regs.svh ***
// Constants for the write checksum and command/address parity checker
`ifndef CRC_PARITY_REGS_SVH
`define CRC_PARITY_REGS_SVH
`define CRC_POLY        8'h07
`define CRC_INIT        8'hff
`define CRC_BITS        8
`define CRC_COVER_BITS  72
`define LANE_COUNT      2
`define BEATS_FULL      4'h8
`define BEATS_CHOP      4'h4
`define ADDR_BITS       17
`define ALERT_SHORT     8'h08
`define ALERT_LONG      8'h60
`endif

// *** design/crc8_lane.sv ***
// Combinational 8-bit checksum over one lane's covered burst field
`include "crc_parity_regs.svh"
module crc8_lane
  import crc_parity_pkg::*;
(
  input  wire logic [`CRC_COVER_BITS-1:0] DATA,
  output logic      [`CRC_BITS-1:0]       CRC
);
  always_comb begin
    logic [`CRC_BITS-1:0] c;
    c = `CRC_INIT;
    for (int i = `CRC_COVER_BITS - 1; i >= 0; i--) begin
      if (c[7] ^ DATA[i]) begin
        c = {c[6:0], 1'b0} ^ `CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    CRC = c;
  end
endmodule

// *** design/crc_parity_check.sv ***
// Write checksum and command/address parity checker with open-drain alert
// Operation
// - 8-bit checksum, polynomial x8+x2+x+1
// - One checksum per burst per lane
// - 72 covered bits, unused bits are ones
// - Mismatch against received checksum flags error
// - Checksum error gives short low alert
// - Detects single, double, odd, one-beat errors
// - Parity covers command strobes and address
// - Clock enable, termination, select excluded
// - Device checks even parity, flags mismatch
// - Parity error gives long low alert
// - Nominal burst is eight beats
// - Burst chop four gives four beats
`include "crc_parity_regs.svh"
module crc_parity_check
  import crc_parity_pkg::*;
(
  input  wire logic                   CLK_SYS,
  input  wire logic                   SRST,
  input  wire logic                   CRC_ENABLE,
  input  wire logic                   PARITY_ENABLE,
  input  wire logic                   CA_VALID,
  input  wire logic                   ACTIVATE_CMD_N,
  input  wire logic                   ROW_STROBE_N,
  input  wire logic                   COL_STROBE_N,
  input  wire logic                   WRITE_STROBE_N,
  input  wire logic [`ADDR_BITS-1:0]  ADDR,
  input  wire logic                   CA_PARITY_IN,
  input  wire logic                   CLOCK_EN,
  input  wire logic                   TERMINATION_CTL,
  input  wire logic                   CHIP_SELECT_N,
  input  wire logic                   BURST_START,
  input  wire logic                   BURST_CHOP_FOUR,
  input  wire logic                   BEAT_VALID,
  input  wire logic [`LANE_COUNT*8-1:0] BEAT_DATA,
  input  wire logic [`LANE_COUNT*8-1:0] CRC_CHECK_BITS,
  output logic                        ERROR_ALERT_OUT,
  output logic                        ERROR_ALERT_OE,
  output logic                        CRC_ERROR,
  output logic                        PARITY_ERROR
);
  localparam int L = `LANE_COUNT;

  typedef struct packed {
    burst_state_type          bstate;
    logic [3:0]               beat;
    logic [3:0]               beats_total;
    logic [L*64-1:0]          data;
    logic [L*8-1:0]           rx_crc;
    alert_state_type          astate;
    logic [7:0]               acount;
    logic                     crc_err;
    logic                     par_err;
    logic [7:0]               alen;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic [L-1:0]   lane_bad;
  logic           par_bad;

  // Per-lane checksum over 64 data bits plus 8 filler ones
  genvar g;
  generate
    for (g = 0; g < L; g++) begin : lane
      logic [`CRC_COVER_BITS-1:0] field;
      logic [`CRC_BITS-1:0]       calc;
      assign field = {s_q.data[g*64 +: 64], 8'hff};
      crc8_lane u_crc (
        .DATA (field),
        .CRC  (calc)
      );
      assign lane_bad[g] = calc != s_q.rx_crc[g*8 +: 8];
    end
  endgenerate

  // Even parity over covered signals; clock enable, termination, select unused
  assign par_bad = ^{ACTIVATE_CMD_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N,
                     ADDR, CA_PARITY_IN};

  always_comb begin
    s_d = s_q;
    s_d.crc_err = 1'b0;
    s_d.par_err = 1'b0;
    case (s_q.bstate)
      IDLE: begin
        if (BURST_START && CRC_ENABLE) begin
          s_d.bstate = BURST;
          s_d.beat = 4'h0;
          s_d.data = '1;
          s_d.beats_total = BURST_CHOP_FOUR ? `BEATS_CHOP : `BEATS_FULL;
        end
      end
      BURST: begin
        if (BEAT_VALID) begin
          for (int l = 0; l < L; l++) begin
            s_d.data[l*64 + (7 - s_q.beat[2:0])*8 +: 8] = BEAT_DATA[l*8 +: 8];
          end
          s_d.beat = s_q.beat + 4'h1;
          if (s_q.beat + 4'h1 == s_q.beats_total) begin
            s_d.rx_crc = CRC_CHECK_BITS;
            s_d.bstate = CHECK;
          end
        end
      end
      CHECK: begin
        s_d.crc_err = |lane_bad;
        s_d.bstate = IDLE;
      end
      default: s_d.bstate = IDLE;
    endcase
    if (CA_VALID && PARITY_ENABLE && !CHIP_SELECT_N && par_bad) begin
      s_d.par_err = 1'b1;
    end
    // Long pulse wins; a checksum error in its last cycle follows it
    // Pulse length is kept for the width check
    if (s_d.par_err) begin
      s_d.astate = ALERT_LONG_PULSE;
      s_d.acount = `ALERT_LONG;
      s_d.alen = 8'h01;
    end else if (s_d.crc_err && (s_q.astate != ALERT_LONG_PULSE || s_q.acount == 8'h01)) begin
      s_d.astate = ALERT_SHORT_PULSE;
      s_d.acount = `ALERT_SHORT;
      s_d.alen = 8'h01;
    end else if (s_q.astate != ALERT_IDLE) begin
      s_d.acount = s_q.acount - 8'h01;
      if (s_q.acount == 8'h01) begin
        s_d.astate = ALERT_IDLE;
      end else begin
        s_d.alen = s_q.alen + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ERROR_ALERT_OUT = 1'b0;
  assign ERROR_ALERT_OE  = s_q.astate != ALERT_IDLE;
  assign CRC_ERROR       = s_q.crc_err;
  assign PARITY_ERROR    = s_q.par_err;

  // Pulse, decode and burst checks
  sequence crc_flag_s;
    CRC_ERROR && !ERROR_ALERT_OE ##0 1'b1;
  endsequence

  sequence last_beat_s;
    s_q.bstate == BURST && BEAT_VALID && s_q.beat + 4'h1 == s_q.beats_total;
  endsequence

  sequence check_step_s;
    s_q.bstate == CHECK ##1 s_q.bstate == IDLE;
  endsequence

  sequence pulse_end_s;
    $fell(ERROR_ALERT_OE) && !$past(SRST);
  endsequence

  a_short_alert_len: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(ERROR_ALERT_OE) && CRC_ERROR && !PARITY_ERROR |-> ERROR_ALERT_OE [*8] ##1 !ERROR_ALERT_OE)
    else $error("short alert length wrong");
  a_long_alert_start: assert property (@(posedge CLK_SYS) disable iff (SRST)
    PARITY_ERROR |-> ERROR_ALERT_OE ##47 ERROR_ALERT_OE)
    else $error("long alert too short");
  a_long_alert_end: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(ERROR_ALERT_OE) && PARITY_ERROR |-> ##[1:144] !ERROR_ALERT_OE || PARITY_ERROR)
    else $error("long alert too long");
  a_parity_flag: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CA_VALID && PARITY_ENABLE && !CHIP_SELECT_N && par_bad |=> PARITY_ERROR)
    else $error("parity error missed");
  a_parity_clean: assert property (@(posedge CLK_SYS) disable iff (SRST)
    PARITY_ERROR |-> $past(par_bad) && $past(CA_VALID))
    else $error("parity error without cause");
  a_crc_flag: assert property (@(posedge CLK_SYS) disable iff (SRST)
    s_q.bstate == CHECK && |lane_bad |=> CRC_ERROR ##0 ERROR_ALERT_OE)
    else $error("checksum error missed");
  a_crc_clean: assert property (@(posedge CLK_SYS) disable iff (SRST)
    s_q.bstate == CHECK && !(|lane_bad) |=> !CRC_ERROR)
    else $error("spurious checksum error");
  a_chop_len: assert property (@(posedge CLK_SYS) disable iff (SRST)
    s_q.bstate == IDLE && BURST_START && CRC_ENABLE && BURST_CHOP_FOUR |=>
      s_q.beats_total == `BEATS_CHOP)
    else $error("chop length wrong");
  a_full_len: assert property (@(posedge CLK_SYS) disable iff (SRST)
    s_q.bstate == IDLE && BURST_START && CRC_ENABLE && !BURST_CHOP_FOUR |=>
      s_q.beats_total == `BEATS_FULL)
    else $error("full length wrong");
  a_alert_level: assert property (@(posedge CLK_SYS) disable iff (SRST)
    crc_flag_s |-> 1'b0)
    else $error("checksum error without alert");

  // Finished pulse must fit the short or the long window
  a_alert_width: assert property (@(posedge CLK_SYS) disable iff (SRST)
    pulse_end_s |->
      (s_q.alen >= 8'h06 && s_q.alen <= 8'h0a) || (s_q.alen >= 8'h30 && s_q.alen <= 8'h90))
    else $error("alert pulse width out of range");
  a_alert_cause: assert property (@(posedge CLK_SYS) disable iff (SRST)
    $rose(ERROR_ALERT_OE) |-> CRC_ERROR || PARITY_ERROR)
    else $error("alert without error");
  a_unselected_quiet: assert property (@(posedge CLK_SYS) disable iff (SRST)
    CA_VALID && CHIP_SELECT_N |=> !PARITY_ERROR)
    else $error("parity checked while deselected");
  a_crc_off_quiet: assert property (@(posedge CLK_SYS) disable iff (SRST)
    s_q.bstate == IDLE && BURST_START && !CRC_ENABLE |=>
      s_q.bstate == IDLE)
    else $error("burst taken with checksum off");
  a_burst_end: assert property (@(posedge CLK_SYS) disable iff (SRST)
    last_beat_s |=> check_step_s)
    else $error("burst did not end in check");
  a_rx_crc_taken: assert property (@(posedge CLK_SYS) disable iff (SRST)
    last_beat_s |=> s_q.rx_crc == $past(CRC_CHECK_BITS))
    else $error("received checksum not taken");
endmodule

// *** testbench/ctl_model.sv ***
// Memory controller model driving commands and write bursts
`include "crc_parity_regs.svh"
module ctl_model (
  input  wire logic                CLK_SYS,
  output logic                     CA_VALID,
  output logic                     ACTIVATE_CMD_N,
  output logic                     ROW_STROBE_N,
  output logic                     COL_STROBE_N,
  output logic                     WRITE_STROBE_N,
  output logic [`ADDR_BITS-1:0]    ADDR,
  output logic                     CA_PARITY_IN,
  output logic                     CLOCK_EN,
  output logic                     TERMINATION_CTL,
  output logic                     CHIP_SELECT_N,
  output logic                     BURST_START,
  output logic                     BURST_CHOP_FOUR,
  output logic                     BEAT_VALID,
  output logic [`LANE_COUNT*8-1:0] BEAT_DATA,
  output logic [`LANE_COUNT*8-1:0] CRC_CHECK_BITS
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {CA_VALID, ACTIVATE_CMD_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N, ADDR, CA_PARITY_IN,
           CLOCK_EN, TERMINATION_CTL, CHIP_SELECT_N, BURST_START, BURST_CHOP_FOUR, BEAT_VALID,
           BEAT_DATA, CRC_CHECK_BITS} = '0;
  function automatic logic [7:0] crc8(input logic [71:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic send_ca(input logic [20:0] ca, input logic cs_n, bad);
    @(negedge CLK_SYS);
    {ACTIVATE_CMD_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N, ADDR} = ca;
    CA_PARITY_IN = ^ca ^ bad;
    {CLOCK_EN, TERMINATION_CTL} = ~ca[1:0];
    CHIP_SELECT_N = cs_n;
    CA_VALID = 1'b1;
    @(negedge CLK_SYS);
    CA_VALID = 1'b0;
    ADDR = ~ADDR;
  endtask
  task automatic write_burst(input logic [63:0] d0, d1, flip, input logic lane, chop);
    logic [71:0] f0, f1;
    logic [63:0] s0, s1;
    f0 = chop ? {d0[63:32], 40'hffffffffff} : {d0, 8'hff};
    f1 = chop ? {d1[63:32], 40'hffffffffff} : {d1, 8'hff};
    s0 = lane ? d0 : d0 ^ flip;
    s1 = lane ? d1 ^ flip : d1;
    @(negedge CLK_SYS);
    BURST_START = 1'b1;
    BURST_CHOP_FOUR = chop;
    for (int i = 0; i < (chop ? 4 : 8); i++) begin
      @(negedge CLK_SYS);
      BURST_START = 1'b0;
      BEAT_VALID = 1'b1;
      BEAT_DATA = {s1[63-8*i -: 8], s0[63-8*i -: 8]};
      CRC_CHECK_BITS = {crc8(f1), crc8(f0)};
    end
    @(negedge CLK_SYS);
    BEAT_VALID = 1'b0;
    BEAT_DATA = ~BEAT_DATA;
    CRC_CHECK_BITS = ~CRC_CHECK_BITS;
  endtask
endmodule

// *** testbench/test_crc_parity_check.sv ***
// Bench for the checksum and parity checker
`include "crc_parity_regs.svh"
module test_crc_parity_check;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_SYS, SRST, CRC_ENABLE, PARITY_ENABLE;
  wire logic CA_VALID, ACTIVATE_CMD_N, ROW_STROBE_N, COL_STROBE_N, WRITE_STROBE_N, CA_PARITY_IN, CLOCK_EN;
  wire logic TERMINATION_CTL, CHIP_SELECT_N, BURST_START, BURST_CHOP_FOUR, BEAT_VALID;
  wire logic [`ADDR_BITS-1:0] ADDR;
  wire logic [`LANE_COUNT*8-1:0] BEAT_DATA, CRC_CHECK_BITS;
  wire logic ERROR_ALERT_OUT, ERROR_ALERT_OE, CRC_ERROR, PARITY_ERROR;
  wire logic alert_pin = ERROR_ALERT_OE ? ERROR_ALERT_OUT : 1'b1;
  int err_count = 0;
  int checks_done = 0;
  crc_parity_check DUT (.CLK_SYS, .SRST, .CRC_ENABLE, .PARITY_ENABLE, .CA_VALID, .ACTIVATE_CMD_N, .ROW_STROBE_N,
    .COL_STROBE_N, .WRITE_STROBE_N, .ADDR, .CA_PARITY_IN, .CLOCK_EN, .TERMINATION_CTL, .CHIP_SELECT_N,
    .BURST_START, .BURST_CHOP_FOUR, .BEAT_VALID, .BEAT_DATA, .CRC_CHECK_BITS, .ERROR_ALERT_OUT,
    .ERROR_ALERT_OE, .CRC_ERROR, .PARITY_ERROR);
  ctl_model ctl (.CLK_SYS, .CA_VALID, .ACTIVATE_CMD_N, .ROW_STROBE_N, .COL_STROBE_N, .WRITE_STROBE_N, .ADDR,
    .CA_PARITY_IN, .CLOCK_EN, .TERMINATION_CTL, .CHIP_SELECT_N, .BURST_START, .BURST_CHOP_FOUR, .BEAT_VALID,
    .BEAT_DATA, .CRC_CHECK_BITS);
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic compare(input string name, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic watch(input string name, input logic [7:0] exp_low, exp_crc, exp_par);
    logic [7:0] low, crc_n, par_n;
    {low, crc_n, par_n} = '0;
    repeat (120) begin
      if (alert_pin === 1'b0) low++;
      if (CRC_ERROR !== 1'b0) crc_n++;
      if (PARITY_ERROR !== 1'b0) par_n++;
      @(negedge CLK_SYS);
    end
    compare({name, " alert low"}, exp_low, low);
    compare({name, " crc pulse"}, exp_crc, crc_n);
    compare({name, " parity pulse"}, exp_par, par_n);
  endtask
  task automatic t_crc_good;
    ctl.write_burst(64'h0123456789abcdef, 64'hfedcba9876543210, 64'h0, 1'b0, 1'b0);
    watch("full good", 8'h00, 8'h00, 8'h00);
    ctl.write_burst(64'h00ff00ff5a5a5a5a, 64'h1122334455667788, 64'h0, 1'b0, 1'b1);
    watch("chop good", 8'h00, 8'h00, 8'h00);
  endtask
  task automatic t_crc_bad;
    ctl.write_burst(64'h0123456789abcdef, 64'hfedcba9876543210, 64'h1, 1'b0, 1'b0);
    watch("single bit", 8'h08, 8'h01, 8'h00);
    ctl.write_burst(64'h0, 64'hffffffffffffffff, 64'h8100000000000000, 1'b1, 1'b0);
    watch("two bits one beat", 8'h08, 8'h01, 8'h00);
    ctl.write_burst(64'h0, 64'h0, 64'h0000000100010001, 1'b0, 1'b0);
    watch("three bits", 8'h08, 8'h01, 8'h00);
    ctl.write_burst(64'haaaaaaaa00000000, 64'h0, 64'h0000000100000000, 1'b0, 1'b1);
    watch("chop bad", 8'h08, 8'h01, 8'h00);
    CRC_ENABLE = 1'b0;
    ctl.write_burst(64'h0, 64'h0, 64'h1, 1'b0, 1'b0);
    watch("checksum off", 8'h00, 8'h00, 8'h00);
    CRC_ENABLE = 1'b1;
  endtask
  task automatic t_parity;
    ctl.send_ca(21'h1a5a5, 1'b0, 1'b0);
    watch("parity good", 8'h00, 8'h00, 8'h00);
    ctl.send_ca(21'h10001, 1'b0, 1'b1);
    watch("parity bad", 8'h60, 8'h00, 8'h01);
    ctl.send_ca(21'h00003, 1'b1, 1'b1);
    watch("not selected", 8'h00, 8'h00, 8'h00);
    PARITY_ENABLE = 1'b0;
    ctl.send_ca(21'h0ffff, 1'b0, 1'b1);
    watch("parity off", 8'h00, 8'h00, 8'h00);
  endtask
  initial begin
    {SRST, CRC_ENABLE, PARITY_ENABLE} = 3'b111;
    repeat (10) @(negedge CLK_SYS);
    SRST = 1'b0;
    t_crc_good();
    t_crc_bad();
    t_parity();
    test_done();
  end
  initial begin
    #400000;
    err_count++;
    test_done();
  end
endmodule
